//--- core/i2c_ssp_map.svh
// register indices, field positions, mode codes and reset values
`ifndef I2C_SSP_MAP_SVH
`define I2C_SSP_MAP_SVH
// register indices; the byte address is four times the index
`define IDX_INTCTL   8'h0b
`define IDX_FLAGS1   8'h0c
`define IDX_SBUF     8'h13
`define IDX_SCTL     8'h14
`define IDX_PCDIR    8'h87
`define IDX_ENAB1    8'h8c
`define IDX_SADDR    8'h93
`define IDX_SSTAT    8'h94
// reset values
`define RST_PCDIR    8'h3f
`define RST_ZERO     8'h00
// implemented bits
`define MASK_PCDIR   8'h3f
`define MASK_FLAGS1  8'hcf
`define MASK_SSTAT_W 8'hc0
// field positions
`define POS_IRQFLAG  3
`define POS_WRITE_COLLISION_FLAG     7
`define POS_OVF      6
`define POS_EN       5
`define POS_CKP      4
`define POS_DA       5
`define POS_STOP     4
`define POS_START    3
`define POS_RW       2
`define POS_UA       1
`define POS_BF       0
`define POS_SDA_DIR  4
`define POS_SCL_DIR  3
// port mode field codes
`define MODE_SLV7    4'h6
`define MODE_SLV10   4'h7
`define MODE_MST     4'hb
`define MODE_MSL7    4'he
`define MODE_MSL10   4'hf
// ten-bit header pattern in the high address byte
`define HDR_TENBIT   5'h1e
`endif

//--- core/i2c_ssp_pkg.sv
// types shared by the serial port design
package i2c_ssp_pkg;
  typedef logic [11:0] apb_addr_t;
  typedef enum logic [2:0] {SIdle, SHigh, SLow, SRecv, SXmit, SSkip}
    slv_state_e;
  typedef struct packed {
    slv_state_e st;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] serialBuf;
    logic [7:0] slaveAddr;
    logic [7:0] serialCtl;
    logic [7:0] serialStat;
    logic [7:0] intCtl;
    logic [7:0] flags1;
    logic [7:0] enab1;
    logic [7:0] portDir;
    logic       ackDrive;
    logic       txLow;
    logic       txBusy;
    logic       stretch;
    logic       holdUa;
    logic       irqPend;
    logic       priorMatch;
    logic       masterActive;
    logic       sclPrev;
    logic       sdaPrev;
    logic [7:0] rdata;
  } ssp_state_s;
endpackage

//--- core/i2c_line_sync.sv
// two-flop synchroniser for the bus lines
`timescale 1ns/1ns
`default_nettype none
module i2c_line_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,    // system clock
  input  wire logic             reset,  // synchronous, active high
  input  wire logic [WIDTH-1:0] din,    // asynchronous line levels
  output logic      [WIDTH-1:0] dout    // synchronised levels
);
  logic [WIDTH-1:0] meta_reg;

  if (WIDTH < 1) begin : g_chk
    $error("i2c_line_sync needs WIDTH of one or more");
  end

  // idle bus lines are high, so reset to ones avoids false edges
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_reg <= '1;
      dout     <= '1;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule
`default_nettype wire

//--- core/i2c_ssp_core.sv
// two-wire serial port: register file, start/stop, slave engine
//
// Functional notes
// - reset or disable clears start, stop bits
// - start/stop bits follow the latest condition
// - firmware takes bus on stop or idle
// - lines driven low via direction bits, slave ack, data and stretch
// - irq flag on start, stop (modes 1011, 1110, 1111), each byte addressed to us
// - mode 1011 master only, 0110/0111 slave only, 1110/1111 shared
// - stop raises irq when bus frees, in modes 1011, 1110, 1111
// - sda low while high expected releases lines
// - arbitration losable in address and data
// - slave keeps receiving after lost arbitration
// - 7-bit match: irq, ack, transmit or receive
// - overflow sets flag and withholds ack
// - transmit holds clock until release bit
// - nack ends transmit, ack continues it
// - 10-bit high write: clear prior, irq
// - ack, stretch until address rewritten
// - low match: prior set, ack, receive
// - 10-bit high read needs prior match
// - buffer read clears full; overflow by write
`timescale 1ns/1ns
`default_nettype none
`include "i2c_ssp_map.svh"
module i2c_ssp_core (
  input  wire logic                  clk,      // 50 MHz system clock
  input  wire logic                  reset,    // synchronous, high
  input  wire logic                  psel,     // apb select
  input  wire logic                  penable,  // apb access phase
  input  wire logic                  pwrite,   // apb direction
  input  wire i2c_ssp_pkg::apb_addr_t paddr,   // apb byte address
  input  wire logic [31:0]           pwdata,   // apb write data
  output logic      [31:0]           prdata,   // apb read data
  output logic                       pready,   // apb ready
  output logic                       pslverr,  // unmapped access
  input  wire logic                  sclIn,    // clock line level
  output logic                       sclOut,   // clock drive value
  output logic                       sclOe,    // clock pulled low
  input  wire logic                  sdaIn,    // data line level
  output logic                       sdaOut,   // data drive value
  output logic                       sdaOe     // data pulled low
);
  import i2c_ssp_pkg::*;

  ssp_state_s state_reg;
  ssp_state_s state_next;
  logic [1:0] lineSync;
  logic       sclS;
  logic       sdaS;
  logic       sclRise;
  logic       sclFall;
  logic       startEv;
  logic       stopEv;
  logic       en;
  logic [3:0] mode;
  logic       slvOn;
  logic       tenBit;
  logic       ssIrq;
  logic       ovfl;
  logic       wrAcc;
  logic       rdAcc;
  logic [7:0] idx;
  logic       hit;
  logic       decide;
  logic       arbLoss;

  function automatic logic isMapped(input logic [7:0] i);
    case (i)
      `IDX_INTCTL, `IDX_FLAGS1, `IDX_SBUF, `IDX_SCTL,
      `IDX_PCDIR, `IDX_ENAB1, `IDX_SADDR, `IDX_SSTAT: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction

  // both lines pass two flops before anything looks at them
  i2c_line_sync #(.WIDTH(2)) u_sync (
    .clk   (clk),
    .reset (reset),
    .din   ({sclIn, sdaIn}),
    .dout  (lineSync)
  );

  // line events and mode decode
  assign sclS    = lineSync[1];
  assign sdaS    = lineSync[0];
  assign sclRise = sclS & ~state_reg.sclPrev;
  assign sclFall = ~sclS & state_reg.sclPrev;
  assign startEv = state_reg.sdaPrev & ~sdaS & sclS & state_reg.sclPrev;
  assign stopEv  = ~state_reg.sdaPrev & sdaS & sclS & state_reg.sclPrev;
  assign en      = state_reg.serialCtl[`POS_EN];
  assign mode    = state_reg.serialCtl[3:0];
  // 1011 leaves the slave idle; the shared modes run both
  assign slvOn   = en & (mode == `MODE_SLV7 || mode == `MODE_SLV10 ||
                         mode == `MODE_MSL7 || mode == `MODE_MSL10);
  assign tenBit  = mode[0];
  assign ssIrq   = mode == `MODE_MST || mode == `MODE_MSL7 ||
                   mode == `MODE_MSL10;
  assign ovfl    = state_reg.serialStat[`POS_BF] |
                   state_reg.serialCtl[`POS_OVF];
  assign decide  = slvOn & sclFall & (state_reg.bitCnt == 4'h8) &
                   state_reg.st != SIdle & state_reg.st != SSkip;
  // a high is expected but the line is low: another master won
  assign arbLoss = en & state_reg.masterActive & sclRise & ~sdaS &
                   state_reg.portDir[`POS_SDA_DIR] &
                   ~state_reg.ackDrive & ~state_reg.txLow;

  // apb decode; zero wait states, read data captured in setup
  assign idx     = paddr[9:2];
  assign hit     = paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00 &&
                   isMapped(idx);
  assign wrAcc   = psel & penable & pwrite & hit;
  assign rdAcc   = psel & penable & ~pwrite & hit;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = {24'h00_0000, state_reg.rdata};

  // pins only ever pull low; a one is sent by releasing
  assign sclOut  = 1'b0;
  assign sdaOut  = 1'b0;
  assign sclOe   = en & (~state_reg.portDir[`POS_SCL_DIR] |
                         state_reg.stretch);
  assign sdaOe   = en & (~state_reg.portDir[`POS_SDA_DIR] |
                         state_reg.ackDrive | state_reg.txLow);

  // next state: software effects first, hardware sets after so they win
  always_comb begin
    state_next = state_reg;
    state_next.sclPrev = sclS;
    state_next.sdaPrev = sdaS;
    // register reads
    if (psel & ~penable) begin
      case (idx)
        `IDX_INTCTL: state_next.rdata = state_reg.intCtl;
        `IDX_FLAGS1: state_next.rdata = state_reg.flags1;
        `IDX_SBUF:   state_next.rdata = state_reg.serialBuf;
        `IDX_SCTL:   state_next.rdata = state_reg.serialCtl;
        `IDX_PCDIR:  state_next.rdata = state_reg.portDir;
        `IDX_ENAB1:  state_next.rdata = state_reg.enab1;
        `IDX_SADDR:  state_next.rdata = state_reg.slaveAddr;
        `IDX_SSTAT:  state_next.rdata = state_reg.serialStat;
        default:     state_next.rdata = `RST_ZERO;
      endcase
    end
    // reading the buffer empties it; overflow stays until written
    if (rdAcc && idx == `IDX_SBUF) begin
      state_next.serialStat[`POS_BF] = 1'b0;
    end
    // register writes; the irq flag is cleared only here
    if (wrAcc) begin
      case (idx)
        `IDX_INTCTL: state_next.intCtl = pwdata[7:0];
        `IDX_FLAGS1: state_next.flags1 = pwdata[7:0] & `MASK_FLAGS1;
        `IDX_SCTL:   state_next.serialCtl = pwdata[7:0];
        `IDX_PCDIR:  state_next.portDir = pwdata[7:0] & `MASK_PCDIR;
        `IDX_ENAB1:  state_next.enab1 = pwdata[7:0];
        `IDX_SSTAT: begin
          state_next.serialStat[7:6] = pwdata[7:6];
        end
        `IDX_SADDR: begin
          // rewriting the address ends the address stretch
          state_next.slaveAddr = pwdata[7:0];
          state_next.serialStat[`POS_UA] = 1'b0;
          if (state_reg.st != SXmit) begin
            state_next.stretch = 1'b0;
          end
        end
        `IDX_SBUF: begin
          // a write while a byte shifts out collides and is dropped
          if (state_reg.txBusy) begin
            state_next.serialCtl[`POS_WRITE_COLLISION_FLAG] = 1'b1;
          end else begin
            state_next.serialBuf = pwdata[7:0];
            state_next.shift = pwdata[7:0];
            state_next.serialStat[`POS_BF] = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // transmit waits with clock low until the release bit is set
    if (slvOn && state_reg.st == SXmit && state_reg.stretch &&
        state_reg.serialCtl[`POS_CKP]) begin
      state_next.stretch = 1'b0;
      state_next.txBusy = 1'b1;
      state_next.txLow = ~state_reg.shift[7];
      state_next.serialStat[`POS_BF] = 1'b0;
    end
    // bit sampling on rising clock; runs even after a lost
    // arbitration so this device can still be addressed
    if (slvOn && sclRise && state_reg.st != SIdle &&
        state_reg.st != SSkip) begin
      if (state_reg.bitCnt == 4'h8) begin
        state_next.bitCnt = 4'h9;
        // master nack after our byte ends the transfer
        if (state_reg.st == SXmit && state_reg.txBusy && sdaS) begin
          state_next.st = SSkip;
        end
      end else if (state_reg.bitCnt < 4'h8) begin
        state_next.bitCnt = state_reg.bitCnt + 4'h1;
        if (state_reg.st != SXmit) begin
          state_next.shift = {state_reg.shift[6:0], sdaS};
        end
      end
    end
    // next data bit goes out on each falling clock
    if (slvOn && sclFall && state_reg.st == SXmit &&
        state_reg.bitCnt != 4'h0 && state_reg.bitCnt < 4'h8) begin
      state_next.shift = {state_reg.shift[6:0], 1'b0};
      state_next.txLow = ~state_reg.shift[6];
    end
    // end of the eighth clock: decide the acknowledge
    if (decide) begin
      state_next.irqPend = 1'b1;
      case (state_reg.st)
        SHigh: begin
          if (!tenBit) begin
            if (state_reg.shift[7:1] == state_reg.slaveAddr[7:1]) begin
              state_next.serialStat[`POS_RW] = state_reg.shift[0];
              state_next.serialStat[`POS_DA] = 1'b0;
              if (state_reg.shift[0]) begin
                // read address: ack and become transmitter
                state_next.ackDrive = 1'b1;
                state_next.serialBuf = state_reg.shift;
                state_next.st = SXmit;
              end else if (ovfl) begin
                state_next.serialCtl[`POS_OVF] = 1'b1;
                state_next.st = SSkip;
              end else begin
                state_next.ackDrive = 1'b1;
                state_next.serialBuf = state_reg.shift;
                state_next.serialStat[`POS_BF] = 1'b1;
                state_next.st = SRecv;
              end
            end else begin
              state_next.irqPend = 1'b0;
              state_next.st = SSkip;
            end
          end else if (state_reg.shift[7:3] == `HDR_TENBIT &&
                       state_reg.shift[7:1] ==
                       state_reg.slaveAddr[7:1]) begin
            state_next.serialStat[`POS_RW] = state_reg.shift[0];
            if (!state_reg.shift[0]) begin
              state_next.priorMatch = 1'b0;
              state_next.serialStat[`POS_UA] = 1'b1;
              if (ovfl) begin
                state_next.serialCtl[`POS_OVF] = 1'b1;
                state_next.st = SSkip;
              end else begin
                state_next.ackDrive = 1'b1;
                state_next.holdUa = 1'b1;
                state_next.serialBuf = state_reg.shift;
                state_next.serialStat[`POS_BF] = 1'b1;
                state_next.st = SLow;
              end
            end else if (state_reg.priorMatch) begin
              state_next.ackDrive = 1'b1;
              state_next.serialBuf = state_reg.shift;
              state_next.st = SXmit;
            end else begin
              state_next.priorMatch = 1'b0;
              state_next.irqPend = 1'b0;
              state_next.st = SSkip;
            end
          end else begin
            state_next.irqPend = 1'b0;
            state_next.st = SSkip;
          end
        end
        SLow: begin
          // low address byte always flags an update request
          state_next.serialStat[`POS_UA] = 1'b1;
          if (state_reg.shift == state_reg.slaveAddr) begin
            state_next.priorMatch = 1'b1;
            state_next.ackDrive = 1'b1;
            state_next.holdUa = 1'b1;
            state_next.serialBuf = state_reg.shift;
            state_next.serialStat[`POS_BF] = 1'b1;
            state_next.st = SRecv;
          end else begin
            state_next.st = SSkip;
          end
        end
        SRecv: begin
          state_next.serialStat[`POS_DA] = 1'b1;
          if (ovfl) begin
            state_next.serialCtl[`POS_OVF] = 1'b1;
          end else begin
            state_next.ackDrive = 1'b1;
            state_next.serialBuf = state_reg.shift;
            state_next.serialStat[`POS_BF] = 1'b1;
          end
        end
        SXmit: begin
          // release data so the master can answer
          state_next.txLow = 1'b0;
          state_next.serialStat[`POS_DA] = 1'b1;
        end
        default: ;
      endcase
    end
    // end of the ninth clock: flag the byte and stretch if needed
    if (slvOn && sclFall && state_reg.bitCnt == 4'h9) begin
      state_next.bitCnt = 4'h0;
      state_next.ackDrive = 1'b0;
      state_next.holdUa = 1'b0;
      if (state_reg.irqPend) begin
        state_next.flags1[`POS_IRQFLAG] = 1'b1;
      end
      state_next.irqPend = 1'b0;
      if (state_reg.st == SXmit) begin
        // ack keeps us transmitting; wait for the next byte
        state_next.serialCtl[`POS_CKP] = 1'b0;
        state_next.stretch = 1'b1;
        state_next.txBusy = 1'b0;
      end else if (state_reg.holdUa) begin
        state_next.stretch = 1'b1;
      end
    end
    if (arbLoss) begin
      state_next.portDir[`POS_SDA_DIR] = 1'b1;
      state_next.portDir[`POS_SCL_DIR] = 1'b1;
      state_next.masterActive = 1'b0;
    end
    // flags mirror the latest condition; readable for bus-free
    // checks by firmware
    if (en && startEv) begin
      state_next.serialStat[`POS_START] = 1'b1;
      state_next.serialStat[`POS_STOP] = 1'b0;
      state_next.masterActive = ~state_reg.portDir[`POS_SDA_DIR];
      state_next.st = slvOn ? SHigh : SIdle;
      state_next.bitCnt = 4'h0;
      if (ssIrq) begin
        state_next.flags1[`POS_IRQFLAG] = 1'b1;
      end
    end
    if (en && stopEv) begin
      state_next.serialStat[`POS_STOP] = 1'b1;
      state_next.serialStat[`POS_START] = 1'b0;
      state_next.masterActive = 1'b0;
      state_next.st = SIdle;
      if (ssIrq) begin
        state_next.flags1[`POS_IRQFLAG] = 1'b1;
      end
    end
    // a new frame or its end drops every slave drive
    if ((en && (startEv || stopEv)) || !slvOn) begin
      state_next.ackDrive = 1'b0;
      state_next.txLow = 1'b0;
      state_next.txBusy = 1'b0;
      state_next.stretch = 1'b0;
      state_next.holdUa = 1'b0;
      state_next.irqPend = 1'b0;
    end
    // disabled port forgets bus conditions and frames
    if (!en) begin
      state_next.serialStat[`POS_START] = 1'b0;
      state_next.serialStat[`POS_STOP] = 1'b0;
      state_next.st = SIdle;
      state_next.bitCnt = 4'h0;
      state_next.masterActive = 1'b0;
    end
  end

  // single state register; reset clears conditions and drives
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.st <= SIdle;
      state_reg.portDir <= `RST_PCDIR;
      state_reg.sclPrev <= 1'b1;
      state_reg.sdaPrev <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_disable_clears: assert property (!en |=>
    !state_reg.serialStat[`POS_START] && !state_reg.serialStat[`POS_STOP])
    else $error("start or stop bit survived disable");
  a_start_flag_set: assert property (en && startEv |=>
    state_reg.serialStat[`POS_START] && !state_reg.serialStat[`POS_STOP])
    else $error("start condition not reflected");
  a_stop_flag_set: assert property (en && stopEv |=>
    state_reg.serialStat[`POS_STOP] && !state_reg.serialStat[`POS_START])
    else $error("stop condition not reflected");
  a_stop_irq: assert property (en && stopEv && ssIrq |=>
    state_reg.flags1[`POS_IRQFLAG])
    else $error("stop did not raise the irq flag");
  a_sda_release: assert property (state_reg.portDir[`POS_SDA_DIR] &&
    !state_reg.ackDrive && !state_reg.txLow |-> !sdaOe)
    else $error("data line pulled without cause");
  a_arb_release: assert property (arbLoss |=>
    state_reg.portDir[`POS_SDA_DIR] && state_reg.portDir[`POS_SCL_DIR]
    && !state_reg.masterActive)
    else $error("lines not released after lost arbitration");
  a_ovf_nack: assert property (decide && state_reg.st == SRecv &&
    ovfl |=> state_reg.serialCtl[`POS_OVF] && !state_reg.ackDrive)
    else $error("overflowed byte was acknowledged");
  a_byte_irq: assert property (slvOn && sclFall &&
    state_reg.bitCnt == 4'h9 && state_reg.irqPend && !startEv && !stopEv
    |=> state_reg.flags1[`POS_IRQFLAG])
    else $error("byte end did not raise the irq flag");
  a_xmit_hold: assert property (slvOn && sclFall && !wrAcc &&
    state_reg.bitCnt == 4'h9 && state_reg.st == SXmit
    |=> sclOe && !state_reg.serialCtl[`POS_CKP])
    else $error("clock not held while waiting to transmit");
  a_read_clr_bf: assert property (rdAcc && idx == `IDX_SBUF &&
    !decide |=> !state_reg.serialStat[`POS_BF])
    else $error("buffer read left the full flag set");
endmodule
`default_nettype wire

//--- test/i2c_bus_model.sv
// behavioural two-wire bus master standing on the far side of the port
`timescale 1ns/1ns
`default_nettype none
module i2c_bus_model (
  input  wire logic clk,     // system clock, paces the 160 ns link clock
  input  wire logic sclLine, // resolved clock line
  input  wire logic sdaLine, // resolved data line
  output var  logic sclPull, // high pulls clock low
  output var  logic sdaPull  // high pulls data low
);
  initial begin
    sclPull = 1'b0;
    sdaPull = 1'b0;
  end
  // half a link period is four system clocks
  task automatic hc();
    repeat (4) @(posedge clk);
  endtask
  // clock is released and then awaited, since the slave may stretch it
  task automatic bitx(input logic b, output logic r);
    int n;
    sdaPull <= !b;
    hc();
    sclPull <= 1'b0;
    @(posedge clk);
    for (n = 0; n < 3000 && sclLine !== 1'b1; n++) @(posedge clk);
    // three more edges keep the high phase at four clocks: 160 ns period
    repeat (3) @(posedge clk);
    r = sdaLine;
    sclPull <= 1'b1;
  endtask
  // one byte msb first plus the ninth bit; 8'hff reads the slave's byte
  task automatic xfer(input logic [7:0] d, input logic ackIn,
                      output logic [7:0] q, output logic ackOut);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(ackIn, ackOut);
  endtask
  task automatic start();
    sdaPull <= 1'b1;
    hc();
    sclPull <= 1'b1;
    hc();
  endtask
  task automatic stop();
    sdaPull <= 1'b1;
    hc();
    sclPull <= 1'b0;
    hc();
    sdaPull <= 1'b0;
    hc();
  endtask
  // the far side pulls or releases data alone, as a rival master would
  task automatic holdSda(input logic v);
    sdaPull <= v;
  endtask
endmodule
`default_nettype wire

//--- test/i2c_master_multimaster_slave_fsm_bench.sv
// self-checking bench: registers over apb, slave traffic, line drive
`timescale 1ns/1ns
`default_nettype none
`include "i2c_ssp_map.svh"
module i2c_master_multimaster_slave_fsm_bench;
  import i2c_ssp_pkg::*;
  logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, slvErr, sclOe, sdaOe, ak;
  logic sclOut, sdaOut, mScl, mSda;
  apb_addr_t paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [7:0] q;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  wire logic sclLine = ~(sclOe | mScl); // pull-up on both lines
  wire logic sdaLine = ~(sdaOe | mSda);
  // {write, index, write data, expected read}
  logic [24:0] rows [8] = '{
    {1'b0, 8'h87, 8'h00, 8'h3f}, {1'b0, 8'h14, 8'h00, 8'h00},
    {1'b0, 8'h94, 8'h00, 8'h00}, {1'b0, 8'h93, 8'h00, 8'h00},
    {1'b0, 8'h0c, 8'h00, 8'h00}, {1'b1, 8'h87, 8'hff, 8'h3f},
    {1'b1, 8'h94, 8'hff, 8'hc0}, {1'b1, 8'h93, 8'ha0, 8'ha0}};
  always #10 clk = ~clk;
  i2c_ssp_core i2c_ssp_core_inst (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclIn(sclLine),
    .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe));
  i2c_bus_model m (.clk(clk), .sclLine(sclLine), .sdaLine(sdaLine),
    .sclPull(mScl), .sdaPull(mSda));
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, got);
    n_compared++;
    if (got !== ex) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // one apb transfer; the idle edge at the end keeps drivers single
  task automatic apb(input logic w, input logic [7:0] ix, wd,
                     output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, ix, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge clk);
    penable <= 1'b1;
    // pready is tied high, so this wait ends after one edge
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // a hang ends in the same closing report
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    foreach (rows[i]) begin
      if (rows[i][24]) apb(1'b1, rows[i][23:16], rows[i][15:8], rd);
      apb(1'b0, rows[i][23:16], 8'h00, rd);
      chk("reg", rows[i][7:0], rd);
    end
    apb(1'b1, `IDX_SSTAT, 8'h00, rd);
    apb(1'b0, 8'h20, 8'h00, rd);
    chk("pslverr", 1, slvErr);
    chk("unmapped", 0, rd);
    // 7-bit slave write, start and stop interrupts on
    apb(1'b1, `IDX_SCTL, 8'h2e, rd);
    m.start();
    apb(1'b0, `IDX_SSTAT, 8'h00, rd);
    chk("start", 8'h08, rd & 8'h18);
    apb(1'b0, `IDX_FLAGS1, 8'h00, rd);
    chk("irq start", 8'h08, rd & 8'h08);
    m.xfer(8'ha0, 1'b1, q, ak);
    chk("addr ack", 0, ak);
    apb(1'b0, `IDX_SBUF, 8'h00, rd);
    chk("addr buf", 8'ha0, rd);
    m.xfer(8'h5a, 1'b1, q, ak);
    chk("data ack", 0, ak);
    apb(1'b0, `IDX_SSTAT, 8'h00, rd);
    chk("full", 1, rd & 8'h01);
    apb(1'b0, `IDX_SBUF, 8'h00, rd);
    chk("data", 8'h5a, rd);
    apb(1'b0, `IDX_SSTAT, 8'h00, rd);
    chk("full clr", 0, rd & 8'h01);
    m.xfer(8'h11, 1'b1, q, ak);
    m.xfer(8'h22, 1'b1, q, ak);
    chk("ovf nack", 1, ak);
    apb(1'b0, `IDX_SCTL, 8'h00, rd);
    chk("ovf", 8'h6e, rd);
    apb(1'b0, `IDX_SBUF, 8'h00, rd);
    chk("kept", 8'h11, rd);
    apb(1'b1, `IDX_SCTL, 8'h2e, rd);
    apb(1'b0, `IDX_SCTL, 8'h00, rd);
    chk("ovf clr", 8'h2e, rd);
    apb(1'b1, `IDX_FLAGS1, 8'h00, rd);
    m.stop();
    apb(1'b0, `IDX_SSTAT, 8'h00, rd);
    chk("stop", 8'h10, rd & 8'h18);
    apb(1'b0, `IDX_FLAGS1, 8'h00, rd);
    chk("irq stop", 8'h08, rd & 8'h08);
    // 7-bit slave read: stretch until data and release bit are given
    m.start();
    m.xfer(8'ha1, 1'b1, q, ak);
    chk("rd ack", 0, ak);
    repeat (20) @(posedge clk);
    chk("stretch", 1, sclOe);
    apb(1'b1, `IDX_SBUF, 8'hc3, rd);
    apb(1'b1, `IDX_SCTL, 8'h3e, rd);
    m.xfer(8'hff, 1'b1, q, ak);
    chk("tx byte", 8'hc3, q);
    repeat (8) @(posedge clk);
    chk("nack idle", 0, {sclOe, sdaOe});
    m.stop();
    // 10-bit slave: high byte, low byte, data, then read after new start
    apb(1'b1, `IDX_SCTL, 8'h2f, rd);
    apb(1'b1, `IDX_SADDR, 8'hf2, rd);
    m.start();
    m.xfer(8'hf2, 1'b1, q, ak);
    chk("hi ack", 0, ak);
    apb(1'b0, `IDX_SSTAT, 8'h00, rd);
    chk("hi ua", 8'h02, rd & 8'h02);
    apb(1'b0, `IDX_SBUF, 8'h00, rd);
    chk("hi buf", 8'hf2, rd);
    chk("hi hold", 1, sclOe);
    apb(1'b1, `IDX_SADDR, 8'h34, rd);
    m.xfer(8'h34, 1'b1, q, ak);
    chk("lo ack", 0, ak);
    apb(1'b0, `IDX_SBUF, 8'h00, rd);
    chk("lo buf", 8'h34, rd);
    apb(1'b0, `IDX_SSTAT, 8'h00, rd);
    chk("lo ua", 8'h02, rd & 8'h03);
    chk("lo hold", 1, sclOe);
    apb(1'b1, `IDX_SADDR, 8'hf2, rd);
    m.xfer(8'h77, 1'b1, q, ak);
    chk("10b ack", 0, ak);
    apb(1'b0, `IDX_SBUF, 8'h00, rd);
    chk("10b data", 8'h77, rd);
    m.stop();
    m.start();
    m.xfer(8'hf3, 1'b1, q, ak);
    chk("hi rd ack", 0, ak);
    apb(1'b1, `IDX_SCTL, 8'h00, rd);
    apb(1'b0, `IDX_SSTAT, 8'h00, rd);
    chk("disable", 0, rd & 8'h18);
    m.stop();
    // master only: data driven low through its direction bit
    apb(1'b1, `IDX_SCTL, 8'h2b, rd);
    apb(1'b1, `IDX_PCDIR, 8'h2f, rd);
    chk("drive low", 1, sdaOe);
    chk("pins", 0, {sclOut, sdaOut});
    apb(1'b1, `IDX_PCDIR, 8'h3f, rd);
    chk("release", 0, sdaOe);
    // own frame, data released for a one, rival holds it low at the rise
    apb(1'b1, `IDX_PCDIR, 8'h2f, rd);
    apb(1'b1, `IDX_PCDIR, 8'h27, rd);
    apb(1'b1, `IDX_PCDIR, 8'h37, rd);
    m.holdSda(1'b1);
    apb(1'b1, `IDX_PCDIR, 8'h3f, rd);
    repeat (8) @(posedge clk);
    m.holdSda(1'b0);
    apb(1'b0, `IDX_PCDIR, 8'h00, rd);
    chk("arb dir", 8'h3f, rd);
    test_done();
  end
endmodule
`default_nettype wire
